// *** design/ssfs_regs.vh ***
// Overview of operation
// - The two-bit address is the plain binary set index, bit 1 most significant.
// - At most four stored parameter sets are supported.
// - A set count of two makes one address bit settable, a larger count makes two.
// - With a count of two only bit 0 is used and it picks set 0 or set 1.
// - With one address bit, either input line a or input line b may drive bit 0.
// - A non-inverted line gives 1 when high, an inverted line gives 1 when low.
// - With a count above two, the lines may map to bits 0 and 1 in either order.
// - With a count of two the address bit pick is held at bit 0.
// - The target set number accepts only the values zero through three.
// - While off, a store copies the working parameters into the target set, replacing it; a store while on is ignored.
// - Each frame trigger while on with the policy bit set and waiting status high samples the lines and loads the addressed set.
// - While a selection line changes, waiting status drops and triggers are ignored.
// - Turning off mid frame finishes the frame, then restores the pre-enable params.
`ifndef SSFS_REGS_VH
`define SSFS_REGS_VH
`define SSFS_OFS_CTRL     12'h000
`define SSFS_OFS_COUNT    12'h004
`define SSFS_OFS_PICK     12'h008
`define SSFS_OFS_SRC      12'h00c
`define SSFS_OFS_TARGET   12'h010
`define SSFS_OFS_STORE    12'h014
`define SSFS_OFS_WORK     12'h018
`define SSFS_OFS_STATUS   12'h01c
`define SSFS_OFS_ACTIVE   12'h020
`define SSFS_CTRL_ON      0
`define SSFS_CTRL_POLICY  1
`define SSFS_SRC_LINE     0
`define SSFS_SRC_INV      1
`define SSFS_MAX_SETS     3'h4
`define SSFS_ONE_BIT_CNT  3'h2
`define SSFS_RST_COUNT    3'h2
`define SSFS_RST_SRC0     2'h0
`define SSFS_RST_SRC1     2'h1
`define SSFS_COUNT_MSB    2
`define SSFS_TARGET_MSB   1
`define SSFS_PICK_BIT     0
`define SSFS_SRC_MSB      1
`define SSFS_PW           32
`define SSFS_NSETS        4
`endif

// *** design/ssfs_line_bit.v ***
`timescale 1ns/1ns
module ssfs_line_bit (
   // line inputs
   input  wire       line_a,
   input  wire       line_b,
   // source choice
   input  wire       use_b,
   input  wire       invert,
   // address bit
   output wire       bit_val
);
   assign bit_val = (use_b ? line_b : line_a) ^ invert;
endmodule // ssfs_line_bit

// *** design/ssfs_edge_watch.v ***
`timescale 1ns/1ns
module ssfs_edge_watch (
   // clocking
   input  wire       clk,
   input  wire       rst,
   input  wire       ce,
   // line inputs
   input  wire       line_a,
   input  wire       line_b,
   input  wire       trig,
   // results
   output wire       line_moving,
   output wire       trig_rise
);
   reg last_a;
   reg last_b;
   reg last_t;
   always @(posedge clk) begin
      if (rst) begin
         last_a <= 1'b0;
         last_b <= 1'b0;
         last_t <= 1'b0;
      end else if (ce) begin
         last_a <= line_a;
         last_b <= line_b;
         last_t <= trig;
      end
   end
   assign line_moving = (last_a != line_a) | (last_b != line_b);
   assign trig_rise   = trig & ~last_t;
endmodule // ssfs_edge_watch

// *** design/ssfs_top.v ***
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "ssfs_regs.vh"
module ssfs_top (
   // clock and reset
   input  wire        CLK,
   input  wire        SYS_RST,
   input  wire        CE,
   // apb slave
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [11:0] PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output reg         PREADY,
   output reg         PSLVERR,
   // external controller
   input  wire        INPUT_LINE_A,
   input  wire        INPUT_LINE_B,
   input  wire        FRAME_TRIG,
   input  wire        FRAME_DONE,
   // acquisition side
   output reg  [31:0] ACTIVE_PARAMS,
   output reg  [1:0]  CURRENT_SET,
   output reg         FRAME_ACTIVE,
   output reg         WAIT_TRIG
);
   reg [31:0] set_mem [0:`SSFS_NSETS-1];
   reg [31:0] working;
   reg [31:0] saved;
   reg        sequencer_on;
   reg        set_advance_policy;
   reg [2:0]  stored_set_count;
   reg        addr_bit_pick;
   reg [1:0]  addr_bit_line_src [0:1];
   reg [1:0]  target_set_number;
   reg        running;
   reg        stop_pending;
   wire       line_moving;
   wire       trig_rise;
   wire [1:0] live_bit;
   wire [1:0] live_addr;
   wire       acc;
   wire       wr;
   wire       two_bits;
   reg [31:0] rd_val;
   reg        rd_err;

   assign acc = PSEL & PENABLE & ~PREADY;
   assign wr  = acc & PWRITE;
   assign two_bits = stored_set_count > `SSFS_ONE_BIT_CNT;

   ssfs_edge_watch u_watch (
      .clk         (CLK),
      .rst         (SYS_RST),
      .ce          (CE),
      .line_a      (INPUT_LINE_A),
      .line_b      (INPUT_LINE_B),
      .trig        (FRAME_TRIG),
      .line_moving (line_moving),
      .trig_rise   (trig_rise)
   );

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_bit
         ssfs_line_bit u_bit (
            .line_a  (INPUT_LINE_A),
            .line_b  (INPUT_LINE_B),
            .use_b   (addr_bit_line_src[g][`SSFS_SRC_LINE]),
            .invert  (addr_bit_line_src[g][`SSFS_SRC_INV]),
            .bit_val (live_bit[g])
         );
      end
   endgenerate

   // one-bit mode forces bit 1 low so only sets 0 and 1 are reachable
   assign live_addr = {live_bit[1] & two_bits, live_bit[0]};

   always @* begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      case (PADDR)
         `SSFS_OFS_CTRL:   rd_val = {30'h0, set_advance_policy, sequencer_on};
         `SSFS_OFS_COUNT:  rd_val = {29'h0, stored_set_count};
         `SSFS_OFS_PICK:   rd_val = {31'h0, addr_bit_pick};
         `SSFS_OFS_SRC:    rd_val = {30'h0, addr_bit_line_src[addr_bit_pick]};
         `SSFS_OFS_TARGET: rd_val = {30'h0, target_set_number};
         `SSFS_OFS_STORE:  rd_val = 32'h0000_0000;
         `SSFS_OFS_WORK:   rd_val = working;
         `SSFS_OFS_STATUS: rd_val = {27'h0, live_addr, stop_pending, running, WAIT_TRIG};
         `SSFS_OFS_ACTIVE: rd_val = set_mem[target_set_number];
         default:          rd_err = 1'b1;
      endcase
   end

   // apb: one wait state, answer in the cycle after the access phase starts
   always @(posedge CLK) begin
      if (SYS_RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PREADY  <= acc;
         PSLVERR <= acc & rd_err;
         if (acc & ~PWRITE)
            PRDATA <= rd_val;
      end
   end

   // configuration registers
   always @(posedge CLK) begin
      if (SYS_RST) begin
         sequencer_on         <= 1'b0;
         set_advance_policy   <= 1'b0;
         stored_set_count     <= `SSFS_RST_COUNT;
         addr_bit_pick        <= 1'b0;
         addr_bit_line_src[0] <= `SSFS_RST_SRC0;
         addr_bit_line_src[1] <= `SSFS_RST_SRC1;
         target_set_number    <= 2'h0;
      end else if (CE & wr) begin
         case (PADDR)
            `SSFS_OFS_CTRL: begin
               sequencer_on       <= PWDATA[`SSFS_CTRL_ON];
               // config other than the target set number is frozen while on; software is expected to stop first
               if (!sequencer_on)
                  set_advance_policy <= PWDATA[`SSFS_CTRL_POLICY];
            end
            `SSFS_OFS_COUNT: begin
               if (!sequencer_on && PWDATA[`SSFS_COUNT_MSB:0] >= `SSFS_ONE_BIT_CNT
                   && PWDATA[`SSFS_COUNT_MSB:0] <= `SSFS_MAX_SETS) begin
                  stored_set_count <= PWDATA[`SSFS_COUNT_MSB:0];
                  if (PWDATA[`SSFS_COUNT_MSB:0] == `SSFS_ONE_BIT_CNT)
                     addr_bit_pick <= 1'b0;
               end
            end
            `SSFS_OFS_PICK:
               if (!sequencer_on)
                  addr_bit_pick <= PWDATA[`SSFS_PICK_BIT] & two_bits;
            `SSFS_OFS_SRC:
               if (!sequencer_on)
                  addr_bit_line_src[addr_bit_pick] <= PWDATA[`SSFS_SRC_MSB:0];
            `SSFS_OFS_TARGET:
               if (PWDATA[31:`SSFS_TARGET_MSB+1] == 30'h0)
                  target_set_number <= PWDATA[`SSFS_TARGET_MSB:0];
            default: ;
         endcase
      end
   end

   // stored sets; no reset so they map onto plain memory
   always @(posedge CLK) begin
      if (CE & wr & (PADDR == `SSFS_OFS_STORE) & ~sequencer_on)
         set_mem[target_set_number] <= working;
   end

   // sequencer run control
   always @(posedge CLK) begin
      if (SYS_RST) begin
         working       <= 32'h0000_0000;
         saved         <= 32'h0000_0000;
         running       <= 1'b0;
         stop_pending  <= 1'b0;
         ACTIVE_PARAMS <= 32'h0000_0000;
         CURRENT_SET   <= 2'h0;
         FRAME_ACTIVE  <= 1'b0;
         WAIT_TRIG     <= 1'b0;
      end else if (CE) begin
         if (wr && PADDR == `SSFS_OFS_WORK && !running)
            working <= PWDATA;
         if (sequencer_on && !running && set_advance_policy) begin
            running <= 1'b1;
            saved   <= working;
         end
         if (running && !sequencer_on)
            stop_pending <= 1'b1;
         if (stop_pending && !FRAME_ACTIVE) begin
            running      <= 1'b0;
            stop_pending <= 1'b0;
            working      <= saved;
         end
         // moving line drops waiting status and masks triggers
         WAIT_TRIG <= running & ~stop_pending & ~FRAME_ACTIVE & ~line_moving;
         if (trig_rise && WAIT_TRIG && !line_moving && running && !stop_pending) begin
            // held here so later line moves cannot change the frame's set
            CURRENT_SET  <= live_addr;
            working      <= set_mem[live_addr];
            FRAME_ACTIVE <= 1'b1;
            // waiting status must drop with the trigger, not one cycle late
            WAIT_TRIG    <= 1'b0;
         end else if (FRAME_DONE) begin
            FRAME_ACTIVE <= 1'b0;
         end
         ACTIVE_PARAMS <= working;
      end
   end
endmodule // ssfs_top

// *** testbench/ssfs_checker.sv ***
`timescale 1ns/1ns
module ssfs_checker (
   // apb
   input wire       CLK, SYS_RST, CE, PSEL, PENABLE, PREADY, PSLVERR,
   // controller side
   input wire       INPUT_LINE_A, INPUT_LINE_B, FRAME_TRIG, FRAME_DONE,
   input wire       FRAME_ACTIVE, WAIT_TRIG,
   input wire [1:0] CURRENT_SET
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   sequence trig_ok;
      CE && $rose(FRAME_TRIG) && WAIT_TRIG && $stable(INPUT_LINE_A) && $stable(INPUT_LINE_B);
   endsequence
   sequence trig_bad;
      CE && $rose(FRAME_TRIG) && !FRAME_ACTIVE && !$stable(INPUT_LINE_A);
   endsequence
   apb_ready_a: assert property (CE && PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("no ready");
   ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held");
   err_ready_a: assert property (PSLVERR |-> PREADY) else $error("lone error");
   trig_take_a: assert property (trig_ok |=> FRAME_ACTIVE && !WAIT_TRIG)
      else $error("trigger lost");
   line_block_a: assert property (trig_bad |=> !FRAME_ACTIVE)
      else $error("trigger taken on line move");
   set_hold_a: assert property (FRAME_ACTIVE && !FRAME_DONE |=> $stable(CURRENT_SET))
      else $error("set moved in frame");
   frame_end_a: assert property (FRAME_ACTIVE && FRAME_DONE |=> !FRAME_ACTIVE)
      else $error("frame kept");
   wait_excl_a: assert property (!(WAIT_TRIG && FRAME_ACTIVE))
      else $error("waiting in frame");
endmodule // ssfs_checker
bind ssfs_top ssfs_checker chk (.*);

// *** testbench/ssfs_ctl_model.sv ***
`timescale 1ns/1ns
module ssfs_ctl_model (
   // device status
   input  wire  clk, wait_trig, frame_active,
   // lines to device
   output logic line_a = 0, line_b = 0, trig = 0, done = 0
);
   int n;
   task start(input logic a, b, g, output logic ok);
      if (g) begin
         @(posedge clk);
         line_a <= ~line_a;
         trig <= 1;
         repeat (3) @(posedge clk);
         trig <= 0;
      end
      @(posedge clk);
      line_a <= a;
      line_b <= b;
      // over 1 us of settling on both sides of the trigger edge
      repeat (22) @(posedge clk);
      for (n = 0; n < 50 && wait_trig !== 1; n++) @(posedge clk);
      trig <= 1;
      for (n = 0; n < 50 && frame_active !== 1; n++) @(posedge clk);
      ok = (n < 50);
      repeat (22) @(posedge clk);
      trig <= 0;
   endtask
   task done_frame;
      repeat ($urandom % 6) @(posedge clk);
      @(posedge clk);
      done <= 1;
      @(posedge clk);
      done <= 0;
   endtask
endmodule // ssfs_ctl_model

// *** testbench/test_sequence_set_free_select.sv ***
`timescale 1ns/1ns
module test_sequence_set_free_select;
   logic        CLK = 0, SYS_RST = 1, CE = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, ACTIVE_PARAMS, pv[4];
   logic [33:0] fq[$], f;
   logic        PREADY, PSLVERR, INPUT_LINE_A, INPUT_LINE_B, FRAME_TRIG, FRAME_DONE;
   logic        FRAME_ACTIVE, WAIT_TRIG, fa1 = 0, fa2 = 0, ok;
   logic [1:0]  CURRENT_SET, m;
   logic [32:0] q[$], e;
   int          fails = 0, n_compared = 0, i, j, k;
   always #25 CLK = ~CLK;
   ssfs_top uut (.*);
   ssfs_ctl_model ctl (.clk(CLK), .wait_trig(WAIT_TRIG), .frame_active(FRAME_ACTIVE),
      .line_a(INPUT_LINE_A), .line_b(INPUT_LINE_B), .trig(FRAME_TRIG), .done(FRAME_DONE));
   task check(input logic [31:0] s, x, input string nm);
      n_compared++;
      if (s !== x) begin
         fails++;
         $display("unexpected %s exp %h seen %h", nm, x, s);
      end
   endtask
   task end_of_test;
      $display("compared %0d failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
      q.push_back(x);
      @(posedge CLK);
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      for (i = 0; i < 20 && PREADY !== 1; i++) @(posedge CLK);
      if (i == 20) begin
         fails++;
         end_of_test;
      end
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d, 33'h0);
   endtask
   task frame(input logic a, b, g, st, input logic [1:0] s);
      fq.push_back({s, pv[s]});
      ctl.start(a, b, g, ok);
      if (!ok) begin
         fails++;
         end_of_test;
      end
      if (st) wr(12'h000, 2);
      ctl.done_frame;
   endtask
   always @(posedge CLK) begin
      fa1 <= FRAME_ACTIVE;
      fa2 <= fa1;
      if (PREADY === 1 && q.size() > 0) begin
         e = q.pop_front();
         check({31'h0, PSLVERR}, {31'h0, e[32]}, "err");
         if (!PWRITE && !e[32]) check(PRDATA, e[31:0], "rdata");
      end
      if (fa1 && !fa2 && fq.size() > 0) begin
         f = fq.pop_front();
         check(ACTIVE_PARAMS, f[31:0], "params");
         check({30'h0, CURRENT_SET}, {30'h0, f[33:32]}, "set");
      end
   end
   initial begin
      k = $urandom(8870);
      repeat (6) @(posedge CLK);
      SYS_RST <= 0;
      apb(0, 12'h004, 0, 33'h2);
      apb(0, 12'h008, 0, 33'h0);
      apb(1, 12'h0fc, 0, 33'h1_0000_0000);
      wr(12'h000, 2);
      for (k = 0; k < 4; k++) begin
         pv[k] = $urandom;
         wr(12'h010, k);
         wr(12'h018, $urandom);
         wr(12'h014, 0);
         wr(12'h018, pv[k]);
         wr(12'h014, 0);
         apb(0, 12'h020, 0, {1'b0, pv[k]});
      end
      wr(12'h010, 5);
      apb(0, 12'h020, 0, {1'b0, pv[3]});
      for (k = 0; k < 4; k++) begin
         wr(12'h00c, k);
         wr(12'h000, 3);
         for (j = 0; j < 4; j++)
            frame(j[0], j[1], k == 1 && j == 0, 0, {1'b0, (k[0] ? j[1] : j[0]) ^ k[1]});
         wr(12'h000, 2);
      end
      wr(12'h004, 4);
      wr(12'h004, 5);
      apb(0, 12'h004, 0, 33'h4);
      for (k = 0; k < 2; k++) begin
         m = $urandom;
         wr(12'h008, 0);
         wr(12'h00c, {m[0], k[0]});
         wr(12'h008, 1);
         wr(12'h00c, {m[1], ~k[0]});
         wr(12'h000, 3);
         wr(12'h004, 2);
         for (j = 0; j < 4; j++)
            frame(j[0], j[1], 0, 0, {(k[0] ? j[0] : j[1]) ^ m[1], (k[0] ? j[1] : j[0]) ^ m[0]});
         wr(12'h000, 2);
      end
      apb(0, 12'h004, 0, 33'h4);
      wr(12'h000, 3);
      apb(0, 12'h01c, 0, {28'h0, ~m[1], ~m[0], 3'h3});
      frame(m[1], m[0], 0, 1, 2'h0);
      apb(0, 12'h018, 0, {1'b0, pv[3]});
      end_of_test;
   end
endmodule // test_sequence_set_free_select
